/* rtl/dscss_div_if.sv */
// Connection between the main block and a fractional tick divider.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface dscss_div_if;
  logic        tick_in;   // Input event, one cycle wide.
  logic [15:0] num;       // Output events per den input events.
  logic [15:0] den;       // Divisor; zero stops the divider.
  logic        tick_out;  // Output event, one cycle wide, registered.

  modport src (output tick_in, output num, output den, input tick_out);
  modport div (input tick_in, input num, input den, output tick_out);
endinterface

/* rtl/dscss_frac_div.sv */
// Fractional tick divider: num output ticks for every den input ticks.
// Assumes at most one output tick per clock is ever needed on average.
`timescale 1ns/100ps
module dscss_frac_div (
  // Clock and reset.
  input  wire logic SYS_CLK,
  input  wire logic RST_N,
  // Divider connection.
  dscss_div_if.div  d
);

  logic [17:0] acc_q;  // Phase accumulator.
  logic [17:0] acc_d;  // Next accumulator value.
  logic [17:0] sum;    // Accumulator plus any new increment.
  logic        fire;   // An output tick is due.

  // Add the increment on each input tick and take one den out when due.
  always_comb begin
    sum   = acc_q + (d.tick_in ? {2'b00, d.num} : 18'h0_0000);
    fire  = (d.den != 16'h0000) && (sum >= {2'b00, d.den});
    acc_d = fire ? (sum - {2'b00, d.den}) : sum;
    if (d.den == 16'h0000) begin
      acc_d = 18'h0_0000;
    end
  end

  // Accumulator register.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_q <= 18'h0_0000;
    end else begin
      acc_q <= acc_d;
    end
  end

  // Output tick comes from a flip-flop.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      d.tick_out <= 1'b0;
    end else begin
      d.tick_out <= fire;
    end
  end

endmodule

/* rtl/dscss_map.svh */
// Offsets, field positions, reset values and timing counts of the
// sample clock source select block.
// Assumes inclusion by bare name from any file that needs these values.
`ifndef DSCSS_MAP_SVH
`define DSCSS_MAP_SVH

// Register indices on the register port.
`define DSCSS_OFS_DATAPATH   8'h01
`define DSCSS_OFS_PLL_CFG    8'h04
`define DSCSS_OFS_STATUS     8'h09

// Datapath configuration fields.
`define DSCSS_IF_MSB         7
`define DSCSS_IF_LSB         6
`define DSCSS_SINGLE_PORT    4

// PLL clock configuration fields.
`define DSCSS_LOOP_BW_MSB    20
`define DSCSS_LOOP_BW_LSB    16
`define DSCSS_PLL_EN         15
`define DSCSS_DIV1_MSB       14
`define DSCSS_DIV1_LSB       13
`define DSCSS_DIV2_MSB       12
`define DSCSS_DIV2_LSB       11
`define DSCSS_BIAS_MSB       10
`define DSCSS_BIAS_LSB       8
`define DSCSS_BAND_MSB       7
`define DSCSS_BAND_LSB       2
`define DSCSS_DRIVE_MSB      1
`define DSCSS_DRIVE_LSB      0

// Status fields.
`define DSCSS_LOCK_BIT       3

// Reset values.
`define DSCSS_DATAPATH_RST   32'h0000_0000
`define DSCSS_PLL_CFG_RST    32'h0000_0000

// Band select codes and the band model used by automatic selection.
`define DSCSS_BAND_AUTO      6'h3F
`define DSCSS_BAND_TOP       6'h3E
`define DSCSS_VCO_BASE_MHZ   16'h03B6
`define DSCSS_BAND_STEP_MHZ  16'h0011

// Timing: clock rate and the lock time for both manual and automatic band.
`define DSCSS_SYS_MHZ        20
`define DSCSS_LOCK_TIME_US   5000
`define DSCSS_LOCK_CYC       (`DSCSS_LOCK_TIME_US * `DSCSS_SYS_MHZ)

`endif

/* rtl/dscss_pkg.sv */
// Types of the sample clock source select block.
// Assumes nothing beyond a SystemVerilog compiler.
package dscss_pkg;

  // Lock sequencer states.
  typedef enum logic [1:0] {
    LK_OFF    = 2'b00,
    LK_SEARCH = 2'b01,
    LK_SETTLE = 2'b10,
    LK_LOCKED = 2'b11
  } dscss_lock_t;

endpackage

/* rtl/dscss_top.sv */
// Sample clock source select: direct or multiplied sample clock, derived
// data clock, PLL lock sequencing with automatic band selection.
// Assumes a synchronous register port and a reference clock pin that is
// asynchronous to SYS_CLK; clocks are modelled as one-cycle ticks.
`timescale 1ns/100ps
`include "dscss_map.svh"

// Summary of operation
// - PLL off: reference clock is sample clock
// - Data clock is sample over ratio times port
// - Interpolation ratio from datapath bits 7:6
// - PLL on: sample clock from multiplier
// - Oscillator runs at reference times both ratios
// - Sample clock runs at reference times ratio two
// - Codes 0 to 62 pick rising bands
// - Data clock follows selected sample clock
// - Code 63 runs automatic band search, readback
// - Lock shown on pin and status bit
// - Dividers from config bits 14:13 and 12:11
module dscss_top #(
  parameter int unsigned LOCK_WAIT_CYCLES = `DSCSS_LOCK_CYC,
  parameter int unsigned FREQ_SCALE       = 1
) (
  // Clock and reset.
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  // Reference clock pin.
  input  wire logic        REFERENCE_CLOCK_IN,
  // Register port.
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  output logic      [31:0] REG_RDATA,
  // Derived clocks as ticks.
  output logic             CONVERTER_SAMPLE_CLOCK,
  output logic             VCO_TICK,
  output logic             DATA_CLOCK_OUT,
  // Lock indicator.
  output logic             PLL_LOCK
);

  logic [31:0] datapath_q;          // Datapath configuration register.
  logic [31:0] pll_cfg_q;           // PLL clock configuration register.
  logic [5:0]  band_q;              // Band in use.
  logic        auto_q;              // Automatic band search pending.
  logic        ref_s1_q;            // First synchroniser stage.
  logic        ref_s2_q;            // Second synchroniser stage.
  logic        ref_s3_q;            // Third synchroniser stage.
  logic        ref_lvl_q;           // Accepted reference level.
  logic        ref_rise;            // Accepted rising edge this cycle.
  logic [15:0] per_cnt_q;           // Cycles since last reference edge.
  logic [15:0] period_q;            // Measured reference period.
  logic [31:0] wait_q;              // Lock settle counter.
  dscss_pkg::dscss_lock_t lk_q;     // Lock sequencer state.
  logic        pll_en;              // PLL enable bit.
  logic [15:0] div1_ratio;          // First divider ratio.
  logic [15:0] div2_ratio;          // Second divider ratio.
  logic [15:0] ifr;                 // Interpolation ratio.
  logic        cfg_wr;              // Write to the PLL configuration.
  logic [31:0] vco_mhz;             // Estimated oscillator frequency.
  logic [5:0]  band_pick;           // Band chosen by the search.
  logic [31:0] rd_d;                // Read data before registering.

  dscss_div_if pll_if ();           // Sample clock multiplier.
  dscss_div_if vco_if ();           // Oscillator model.
  dscss_div_if dat_if ();           // Data clock divider.

  // Ratios decode as powers of two from their two-bit codes.
  assign div1_ratio =
    16'h0001 << pll_cfg_q[`DSCSS_DIV1_MSB:`DSCSS_DIV1_LSB];
  assign div2_ratio =
    16'h0001 << pll_cfg_q[`DSCSS_DIV2_MSB:`DSCSS_DIV2_LSB];
  assign ifr = 16'h0001 << datapath_q[`DSCSS_IF_MSB:`DSCSS_IF_LSB];
  assign pll_en = pll_cfg_q[`DSCSS_PLL_EN];
  assign cfg_wr = REG_WR && (REG_ADDR == `DSCSS_OFS_PLL_CFG);

  // Three-stage synchroniser; a level counts once stages two and three
  // agree, so the first stage feeds nothing but the second.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ref_s1_q  <= 1'b0;
      ref_s2_q  <= 1'b0;
      ref_s3_q  <= 1'b0;
      ref_lvl_q <= 1'b0;
    end else begin
      ref_s1_q <= REFERENCE_CLOCK_IN;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
      if (ref_s2_q == ref_s3_q) begin
        ref_lvl_q <= ref_s3_q;
      end
    end
  end

  assign ref_rise = (ref_s2_q == ref_s3_q) && ref_s3_q && !ref_lvl_q;

  // Reference period measurement; counting starts at the first edge, so
  // the period is valid from the second edge; a stall clears the period.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      per_cnt_q <= 16'h0000;
      period_q  <= 16'h0000;
    end else if (ref_rise) begin
      per_cnt_q <= 16'h0001;
      period_q  <= per_cnt_q;
    end else if (per_cnt_q == 16'hFFFF) begin
      period_q <= 16'h0000;
    end else if (per_cnt_q != 16'h0000) begin
      per_cnt_q <= per_cnt_q + 16'h0001;
    end
  end

  // Multiplier: second-ratio sample ticks per reference period.
  assign pll_if.tick_in = pll_en;
  assign pll_if.num     = div2_ratio;
  assign pll_if.den     = period_q;

  // Oscillator: product of both ratios in ticks per reference period.
  assign vco_if.tick_in = pll_en;
  assign vco_if.num     = 16'(div1_ratio * div2_ratio);
  assign vco_if.den     = period_q;

  dscss_frac_div u_pll_div (
    .SYS_CLK (SYS_CLK),
    .RST_N   (RST_N),
    .d       (pll_if.div)
  );

  dscss_frac_div u_vco_div (
    .SYS_CLK (SYS_CLK),
    .RST_N   (RST_N),
    .d       (vco_if.div)
  );

  // Sample clock source select, registered.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CONVERTER_SAMPLE_CLOCK <= 1'b0;
      VCO_TICK               <= 1'b0;
    end else begin
      if (pll_en) begin
        CONVERTER_SAMPLE_CLOCK <= pll_if.tick_out;
      end else begin
        CONVERTER_SAMPLE_CLOCK <= ref_rise;
      end
      VCO_TICK <= vco_if.tick_out;
    end
  end

  // Data clock follows the selected sample clock: one tick per IF*P
  // samples, with P of one half doubling the rate in single-port mode.
  assign dat_if.tick_in = CONVERTER_SAMPLE_CLOCK;
  assign dat_if.num = datapath_q[`DSCSS_SINGLE_PORT] ? 16'h0002
                                                     : 16'h0001;
  assign dat_if.den = ifr;

  dscss_frac_div u_dat_div (
    .SYS_CLK (SYS_CLK),
    .RST_N   (RST_N),
    .d       (dat_if.div)
  );

  assign DATA_CLOCK_OUT = dat_if.tick_out;

  // Oscillator estimate and the band whose range it falls in; bands are
  // spaced evenly upward from code zero and clamp at the top code.
  always_comb begin
    vco_mhz = 32'h0000_0000;
    if (period_q != 16'h0000) begin
      vco_mhz = (32'(`DSCSS_SYS_MHZ) * 32'(div1_ratio) * 32'(div2_ratio)
                 * 32'(FREQ_SCALE)) / 32'(period_q);
    end
    if (vco_mhz <= 32'(`DSCSS_VCO_BASE_MHZ)) begin
      band_pick = 6'h00;
    end else if ((vco_mhz - 32'(`DSCSS_VCO_BASE_MHZ))
                 / 32'(`DSCSS_BAND_STEP_MHZ) >= 32'(`DSCSS_BAND_TOP)) begin
      band_pick = `DSCSS_BAND_TOP;
    end else begin
      band_pick = 6'((vco_mhz - 32'(`DSCSS_VCO_BASE_MHZ))
                     / 32'(`DSCSS_BAND_STEP_MHZ));
    end
  end

  // Configuration registers.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      datapath_q <= `DSCSS_DATAPATH_RST;
      pll_cfg_q  <= `DSCSS_PLL_CFG_RST;
    end else if (REG_WR) begin
      if (REG_ADDR == `DSCSS_OFS_DATAPATH) begin
        datapath_q <= REG_WDATA;
      end
      if (cfg_wr) begin
        pll_cfg_q <= REG_WDATA;
      end
    end
  end

  // Band in use: a plain code is taken as written, the all-ones code
  // starts a search whose result replaces it.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      band_q <= 6'h00;
      auto_q <= 1'b0;
    end else if (cfg_wr) begin
      if (REG_WDATA[`DSCSS_BAND_MSB:`DSCSS_BAND_LSB] == `DSCSS_BAND_AUTO)
      begin
        auto_q <= 1'b1;
      end else begin
        auto_q <= 1'b0;
        band_q <= REG_WDATA[`DSCSS_BAND_MSB:`DSCSS_BAND_LSB];
      end
    end else if (lk_q == dscss_pkg::LK_SEARCH && period_q != 16'h0000)
    begin
      band_q <= band_pick;
      auto_q <= 1'b0;
    end
  end

  // Lock sequencer: any PLL configuration write restarts it; losing the
  // reference or disabling the PLL drops lock.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lk_q   <= dscss_pkg::LK_OFF;
      wait_q <= 32'h0000_0000;
    end else if (cfg_wr || !pll_en || period_q == 16'h0000) begin
      lk_q   <= dscss_pkg::LK_OFF;
      wait_q <= 32'h0000_0000;
    end else begin
      case (lk_q)
        dscss_pkg::LK_OFF: begin
          lk_q <= auto_q ? dscss_pkg::LK_SEARCH : dscss_pkg::LK_SETTLE;
        end
        dscss_pkg::LK_SEARCH: begin
          lk_q <= dscss_pkg::LK_SETTLE;
        end
        dscss_pkg::LK_SETTLE: begin
          if (wait_q >= 32'(LOCK_WAIT_CYCLES) - 32'h0000_0001) begin
            lk_q <= dscss_pkg::LK_LOCKED;
          end else begin
            wait_q <= wait_q + 32'h0000_0001;
          end
        end
        dscss_pkg::LK_LOCKED: begin
          lk_q <= dscss_pkg::LK_LOCKED;
        end
        default: begin
          lk_q <= dscss_pkg::LK_OFF;
        end
      endcase
    end
  end

  // Lock pin from a flip-flop, following the sequencer one cycle later.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PLL_LOCK <= 1'b0;
    end else begin
      PLL_LOCK <= (lk_q == dscss_pkg::LK_LOCKED);
    end
  end

  // Read multiplexer; the band field shows the code in use, or all ones
  // while a search is pending.
  always_comb begin
    rd_d = 32'h0000_0000;
    case (REG_ADDR)
      `DSCSS_OFS_DATAPATH: begin
        rd_d = datapath_q;
      end
      `DSCSS_OFS_PLL_CFG: begin
        rd_d = pll_cfg_q;
        rd_d[`DSCSS_BAND_MSB:`DSCSS_BAND_LSB] =
          auto_q ? `DSCSS_BAND_AUTO : band_q;
      end
      `DSCSS_OFS_STATUS: begin
        rd_d[`DSCSS_LOCK_BIT] = PLL_LOCK;
      end
      default: begin
        rd_d = 32'h0000_0000;
      end
    endcase
  end

  // Read data register, loaded on a read strobe.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 32'h0000_0000;
    end else if (REG_RD) begin
      REG_RDATA <= rd_d;
    end
  end

endmodule

/* tb/dscss_asserts.sv */
// Port checker for the sample clock source select block.
// Assumes binding to dscss_top and a host that waits for each lock.
`timescale 1ns/100ps
module dscss_asserts #(
  parameter int unsigned LOCK_WAIT_CYCLES = 8
) (
  // Clock and reset.
  input wire logic        SYS_CLK,
  input wire logic        RST_N,
  // Inputs.
  input wire logic        REFERENCE_CLOCK_IN,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [7:0]  REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  // Outputs.
  input wire logic [31:0] REG_RDATA,
  input wire logic        CONVERTER_SAMPLE_CLOCK,
  input wire logic        VCO_TICK,
  input wire logic        DATA_CLOCK_OUT,
  input wire logic        PLL_LOCK
);
  localparam int AUTO_LAT = LOCK_WAIT_CYCLES + 3;  // Last low cycle.
  localparam int MAN_LAT  = LOCK_WAIT_CYCLES + 2;  // Last low cycle.
  logic [31:0] dp_q;   // Copy of the datapath word.
  logic [31:0] cfg_q;  // Copy of the PLL word.
  logic [3:0]  age_q;  // Cycles since the last write, saturating.
  logic        wr_cfg; // Write to the PLL word.
  assign wr_cfg = REG_WR && REG_ADDR == 8'h04;
  // Shadow the host writes so reads and modes can be predicted.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dp_q  <= 32'h0000_0000;
      cfg_q <= 32'h0000_0000;
    end else if (REG_WR && REG_ADDR == 8'h01) begin
      dp_q <= REG_WDATA;
    end else if (wr_cfg) begin
      cfg_q <= REG_WDATA;
    end
  end
  // Age lets pipelined ticks from an old setting drain first.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      age_q <= 4'h0;
    end else if (REG_WR) begin
      age_q <= 4'h0;
    end else if (age_q != 4'hF) begin
      age_q <= age_q + 4'h1;
    end
  end
  default clocking dcb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  AST_DIRECT: assert property (
    !cfg_q[15] && age_q > 4'h5 && $rose(REFERENCE_CLOCK_IN)
    |-> ##[3:5] CONVERTER_SAMPLE_CLOCK)
    else $error("no sample tick after reference edge");
  AST_VCO_OFF: assert property (
    !cfg_q[15] && age_q > 4'h2 |-> !VCO_TICK)
    else $error("oscillator tick with multiplier off");
  AST_LOCK_OFF: assert property (
    !cfg_q[15] && age_q > 4'h2 |-> !PLL_LOCK)
    else $error("lock high with multiplier off");
  AST_DATA_CAUSE: assert property (
    DATA_CLOCK_OUT && !dp_q[4] && age_q > 4'h8
    |-> $past(CONVERTER_SAMPLE_CLOCK, 1))
    else $error("data tick without sample tick");
  AST_DATA_EACH: assert property (
    CONVERTER_SAMPLE_CLOCK && dp_q[7:4] == 4'h0 && age_q > 4'h8
    |-> ##1 DATA_CLOCK_OUT)
    else $error("data tick missing at ratio one");
  AST_RD_STATUS: assert property (
    REG_RD && REG_ADDR == 8'h09
    |=> REG_RDATA == {28'h000_0000, $past(PLL_LOCK), 3'h0})
    else $error("status read differs from lock");
  AST_RD_DATAPATH: assert property (
    REG_RD && REG_ADDR == 8'h01 |=> REG_RDATA == $past(dp_q))
    else $error("datapath read differs");
  AST_RD_CFG: assert property (
    REG_RD && REG_ADDR == 8'h04 |=> (REG_RDATA & 32'hFFFF_FF03)
    == ($past(cfg_q) & 32'hFFFF_FF03))
    else $error("clock word read differs");
  AST_RESTART: assert property (
    wr_cfg |-> ##2 !PLL_LOCK [*8])
    else $error("lock not restarted by write");
  AST_LOCK_AUTO: assert property (
    wr_cfg && cfg_q[15] && REG_WDATA[15] && REG_WDATA[7:2] == 6'h3F
    |-> ##AUTO_LAT !PLL_LOCK ##1 PLL_LOCK)
    else $error("automatic band lock time wrong");
  AST_LOCK_MAN: assert property (
    wr_cfg && cfg_q[15] && REG_WDATA[15] && REG_WDATA[7:2] != 6'h3F
    |-> ##MAN_LAT !PLL_LOCK ##1 PLL_LOCK)
    else $error("manual band lock time wrong");
endmodule
bind dscss_top dscss_asserts #(
  .LOCK_WAIT_CYCLES(LOCK_WAIT_CYCLES)
) dscss_asserts_inst (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .REFERENCE_CLOCK_IN(REFERENCE_CLOCK_IN), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_RDATA(REG_RDATA), .CONVERTER_SAMPLE_CLOCK(CONVERTER_SAMPLE_CLOCK),
  .VCO_TICK(VCO_TICK), .DATA_CLOCK_OUT(DATA_CLOCK_OUT),
  .PLL_LOCK(PLL_LOCK)
);

/* tb/dscss_ref_src.sv */
// Reference clock source model standing at the reference clock pin.
// Assumes a period that is a whole number of 50 ns system cycles.
`timescale 1ns/100ps
module dscss_ref_src #(
  parameter int PER_NS = 4000
) (
  // Clock pin.
  output logic ref_clk
);
  // Square wave whose phase is unrelated to the system clock.
  initial begin
    ref_clk = 1'b0;
    #13;
    forever begin
      #(PER_NS / 2) ref_clk = ~ref_clk;
    end
  end
endmodule

/* tb/tb.sv */
// Self-checking bench for the sample clock source select block.
// Assumes the reference source model and the bound port checker.
`timescale 1ns/100ps
module tb;
  localparam int W    = 8;       // Shortened lock wait.
  localparam int P    = 80;      // Reference period in system cycles.
  localparam int WIN  = 16 * P;  // Tick counting window.
  localparam int BAND = (20 * 64 * P / P - 950) / 17;  // Searched band.
  localparam logic [31:0] CFG = 32'h000F_FB03;  // PLL on, x8 x8.
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ref_clk;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata;
  logic        smp, vco, dat, lock, sp;
  logic        clr = 1'b1;     // Clears the tick counters.
  logic        rd_seen = 1'b0; // Read data is due.
  int          n_smp, n_vco, n_dat;
  int          num_errors = 0;
  int          compares = 0;
  logic [31:0] exp_q[$];       // Expected read words, oldest first.
  always #25 sys_clk = ~sys_clk;
  dscss_ref_src #(.PER_NS(P * 50)) dscss_ref_src_inst (.ref_clk(ref_clk));
  dscss_top #(.LOCK_WAIT_CYCLES(W), .FREQ_SCALE(P)) dscss_top_inst (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .REFERENCE_CLOCK_IN(ref_clk),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .CONVERTER_SAMPLE_CLOCK(smp), .VCO_TICK(vco),
    .DATA_CLOCK_OUT(dat), .PLL_LOCK(lock));
  // Count ticks and note which edge launched a read.
  always @(posedge sys_clk) begin
    rd_seen <= reg_rd;
    n_smp <= clr ? 0 : n_smp + int'(smp === 1'b1);
    n_vco <= clr ? 0 : n_vco + int'(vco === 1'b1);
    n_dat <= clr ? 0 : n_dat + int'(dat === 1'b1);
  end
  // Read data has settled by the falling edge; match the oldest note.
  always @(negedge sys_clk) begin
    if (rd_seen) begin
      check_rd(exp_q.pop_front(), reg_rdata);
    end
  end
  task automatic check_rd(input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value read data expected %h seen %h", e, g);
    end
  endtask
  task automatic check_cnt(input string n, input int e, input int g);
    compares++;
    if (g != e) begin
      num_errors++;
      $display("wrong value %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge sys_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    exp_q.push_back(e);
    @(negedge sys_clk);
    reg_rd = 1'b0;
  endtask
  // Counts ticks over a whole number of reference periods.
  task automatic count(input int es, input int ev, input int ed);
    @(negedge sys_clk) clr = 1'b1;
    @(negedge sys_clk) clr = 1'b0;
    repeat (WIN) @(negedge sys_clk);
    check_cnt("sample ticks", es, n_smp);
    check_cnt("oscillator ticks", ev, n_vco);
    check_cnt("data ticks", ed, n_dat);
  endtask
  // Bounded wait for lock after a write to the clock word.
  task automatic wait_lock();
    repeat (4) @(negedge sys_clk);
    for (int i = 0; i < 300 && lock !== 1'b1; i++) @(negedge sys_clk);
    if (lock !== 1'b1) begin
      num_errors++;
      $display("wrong value lock expected 1 seen %b", lock);
      stop_test();
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'h4fcd));
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    rd(8'h01, 32'h0000_0000);
    rd(8'h04, 32'h0000_0000);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0000_0000);
    wr(8'h09, 32'hFFFF_FFFF);
    rd(8'h09, 32'h0000_0000);
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      sp = 1'($urandom % 2);
      wr(8'h01, {24'h00_0000, 2'(k), 1'b0, sp, 4'h0});
      rd(8'h01, {24'h00_0000, 2'(k), 1'b0, sp, 4'h0});
      repeat (2 * P) @(negedge sys_clk);
      count(WIN / P, 0, ((WIN / P) * (int'(sp) + 1)) >> k);
    end
    $display("test direct done");
    wr(8'h01, 32'h0000_0000);
    wr(8'h04, CFG | 32'(BAND << 2));
    wait_lock();
    rd(8'h09, 32'h0000_0008);
    count(16 * 8, 16 * 64, 16 * 8);
    wr(8'h04, CFG | 32'h0000_00FC);
    wait_lock();
    rd(8'h04, CFG | 32'(BAND << 2));
    wr(8'h04, CFG | 32'(BAND << 2));
    wait_lock();
    $display("test multiplied done");
    wr(8'h04, CFG & 32'hFFFF_7FFF);
    rd(8'h09, 32'h0000_0000);
    count(WIN / P, 0, WIN / P);
    $display("test bypass done");
    stop_test();
  end
endmodule
